// file: rtl/pcf_clock_fanout.sv
// clock fanout control: bank ratio, output enable, bypass, phase slip and lock
`timescale 1ns/1ps
module pcf_clock_fanout
    import pcf_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = STAB_MIN_CYC
) (
    input  wire logic                 CORE_CLK,
    input  wire logic                 RST,
    input  wire logic [ADDR_W-1:0]    ADDRESS,
    input  wire logic                 READ,
    input  wire logic                 WRITE,
    input  wire logic [31:0]          WRITEDATA,
    output logic      [31:0]          READDATA,
    output logic                      WAITREQUEST,
    input  wire logic                 REFERENCE_CLOCK_INPUT,
    input  wire logic                 LOOP_FEEDBACK_INPUT,
    output logic      [BANK_OUTS-1:0] BANK_ONE_CLOCK_OUTPUTS,
    output logic      [BANK_OUTS-1:0] BANK_TWO_CLOCK_OUTPUTS,
    output logic      [BANK_OUTS-1:0] BANK_THREE_CLOCK_OUTPUTS,
    output logic      [BANK_OUTS-1:0] BANK_FOUR_CLOCK_OUTPUTS,
    output logic      [BANK_OUTS-1:0] BANK_ONE_OE_N,
    output logic      [BANK_OUTS-1:0] BANK_TWO_OE_N,
    output logic      [BANK_OUTS-1:0] BANK_THREE_OE_N,
    output logic      [BANK_OUTS-1:0] BANK_FOUR_OE_N
);

    // bank b (0..2) runs at the slow quarter rate when the select code exceeds it; bank 3 never does
    function automatic logic bank_slow(input logic [1:0] code, input int unsigned b);
        logic slow;
        slow = 1'b0;
        if (b < NUM_BANKS - 1) begin
            slow = (32'(code) > b);
        end
        return slow;
    endfunction

    // ---------------- register bus ----------------
    pcf_bus_state_t  bus_state;
    pcf_bus_state_t  next_bus_state;
    pcf_ctrl_t       ctrl;
    pcf_ctrl_t       next_ctrl;
    logic [31:0]     next_readdata;
    logic            next_waitrequest;
    logic            locked;
    logic            phase_ok;

    always_comb begin
        next_bus_state   = bus_state;
        next_ctrl        = ctrl;
        next_readdata    = READDATA;
        next_waitrequest = 1'b1;
        case (bus_state)
            PCF_BUS_IDLE: begin
                if (READ || WRITE) begin
                    next_bus_state   = PCF_BUS_ACK;
                    next_waitrequest = 1'b0;
                    next_readdata    = '0;
                    if (ADDRESS == CTRL_ADDR) begin
                        next_readdata[4:0] = ctrl;
                    end else if (ADDRESS == STATUS_ADDR) begin
                        next_readdata[STAT_LOCKED]   = locked;
                        next_readdata[STAT_PHASE_OK] = phase_ok;
                        next_readdata[STAT_TEST]     = ctrl.test_mode;
                        next_readdata[STAT_OUT_OFF]  = ctrl.oe_n;
                    end
                end
            end
            PCF_BUS_ACK: begin
                // the master samples waitrequest low here; the write lands now
                if (WRITE && ADDRESS == CTRL_ADDR) begin
                    next_ctrl.sel_low   = WRITEDATA[CTRL_SEL_LOW];
                    next_ctrl.sel_high  = WRITEDATA[CTRL_SEL_HIGH];
                    next_ctrl.oe_n      = WRITEDATA[CTRL_OE_N];
                    next_ctrl.test_mode = WRITEDATA[CTRL_TEST];
                    // stored and read back only, it steers nothing
                    next_ctrl.clear     = WRITEDATA[CTRL_CLEAR];
                end
                next_bus_state = PCF_BUS_DONE;
            end
            PCF_BUS_DONE: begin
                next_bus_state = PCF_BUS_IDLE;
            end
            default: begin
                next_bus_state = PCF_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            bus_state   <= PCF_BUS_IDLE;
            ctrl        <= pcf_ctrl_t'(CTRL_RESET);
            READDATA    <= '0;
            WAITREQUEST <= 1'b1;
        end else begin
            bus_state   <= next_bus_state;
            ctrl        <= next_ctrl;
            READDATA    <= next_readdata;
            WAITREQUEST <= next_waitrequest;
        end
    end

    // ---------------- pin synchronisers ----------------
    logic [1:0] ref_sync;
    logic [1:0] fb_sync;
    logic       ref_prev;
    logic       fb_prev;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ref_sync <= '0;
            fb_sync  <= '0;
            ref_prev <= 1'b0;
            fb_prev  <= 1'b0;
        end else begin
            ref_sync <= {ref_sync[0], REFERENCE_CLOCK_INPUT};
            fb_sync  <= {fb_sync[0], LOOP_FEEDBACK_INPUT};
            ref_prev <= ref_sync[1];
            fb_prev  <= fb_sync[1];
        end
    end

    logic ref_rise;
    logic fb_rise;
    logic loop_active;

    assign ref_rise    = ref_sync[1] && !ref_prev;
    assign fb_rise     = fb_sync[1] && !fb_prev;
    // with outputs floating the feedback path is open, so no correction is made
    assign loop_active = !ctrl.test_mode && !ctrl.oe_n;

    // ---------------- oscillator model and phase slip ----------------
    logic [1:0] div;
    logic [1:0] next_div;
    logic       slip;
    logic       next_phase_ok;
    logic       slip_wait;
    logic       next_slip_wait;

    // a reference edge without a feedback edge means the loop is off phase:
    // hold the divider one cycle so the feedback edge moves toward it
    assign slip = loop_active && ref_rise && !fb_rise && !slip_wait;

    // the feedback pipeline is as long as one reference period, so the next
    // reference edge still shows the old phase; judging it would slip forever
    always_comb begin
        next_div       = slip ? div : div + 2'h1;
        next_phase_ok  = phase_ok;
        next_slip_wait = slip_wait;
        if (!loop_active) begin
            next_phase_ok  = 1'b0;
            next_slip_wait = 1'b0;
        end else if (ref_rise) begin
            next_phase_ok  = fb_rise;
            next_slip_wait = slip;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            div       <= DIV_RESET;
            phase_ok  <= 1'b0;
            slip_wait <= 1'b0;
        end else begin
            div       <= next_div;
            phase_ok  <= next_phase_ok;
            slip_wait <= next_slip_wait;
        end
    end

    // ---------------- restart detection and lock timer ----------------
    pcf_ctrl_t ctrl_prev;
    logic      seen_reset;
    logic      restart;
    logic      lock_done;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ctrl_prev  <= pcf_ctrl_t'(CTRL_RESET);
            seen_reset <= 1'b1;
        end else begin
            ctrl_prev  <= ctrl;
            seen_reset <= 1'b0;
        end
    end

    // power-up, enable, select change and leaving bypass all restart the interval
    assign restart = seen_reset
                  || (ctrl_prev.oe_n && !ctrl.oe_n)
                  || (ctrl_prev.sel_low != ctrl.sel_low)
                  || (ctrl_prev.sel_high != ctrl.sel_high)
                  || (ctrl_prev.test_mode && !ctrl.test_mode);

    pcf_lock_timer #(
        .CYCLES (STAB_CYCLES)
    ) u_lock_timer (
        .clk     (CORE_CLK),
        .rst     (RST),
        .restart (restart),
        .done    (lock_done)
    );

    assign locked = lock_done && loop_active;

    // ---------------- output banks ----------------
    logic [NUM_BANKS*BANK_OUTS-1:0] next_outs;
    logic [NUM_BANKS*BANK_OUTS-1:0] next_oe_n;
    logic [NUM_BANKS*BANK_OUTS-1:0] outs;
    logic [NUM_BANKS*BANK_OUTS-1:0] oe_n_q;

    always_comb begin
        logic bit_val;
        bit_val   = 1'b0;
        next_outs = '0;
        next_oe_n = '1;
        for (int unsigned b = 0; b < NUM_BANKS; b++) begin
            if (ctrl.test_mode) begin
                bit_val = ref_sync[1];
            end else if (bank_slow({ctrl.sel_high, ctrl.sel_low}, b)) begin
                bit_val = div[1];
            end else begin
                bit_val = div[0];
            end
            for (int unsigned k = 0; k < BANK_OUTS; k++) begin
                next_outs[b*BANK_OUTS+k] = ctrl.oe_n ? 1'b0 : bit_val;
                next_oe_n[b*BANK_OUTS+k] = ctrl.oe_n;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            outs   <= '0;
            oe_n_q <= '1;
        end else begin
            outs   <= next_outs;
            oe_n_q <= next_oe_n;
        end
    end

    assign BANK_ONE_CLOCK_OUTPUTS   = outs[0*BANK_OUTS +: BANK_OUTS];
    assign BANK_TWO_CLOCK_OUTPUTS   = outs[1*BANK_OUTS +: BANK_OUTS];
    assign BANK_THREE_CLOCK_OUTPUTS = outs[2*BANK_OUTS +: BANK_OUTS];
    assign BANK_FOUR_CLOCK_OUTPUTS  = outs[3*BANK_OUTS +: BANK_OUTS];
    assign BANK_ONE_OE_N            = oe_n_q[0*BANK_OUTS +: BANK_OUTS];
    assign BANK_TWO_OE_N            = oe_n_q[1*BANK_OUTS +: BANK_OUTS];
    assign BANK_THREE_OE_N          = oe_n_q[2*BANK_OUTS +: BANK_OUTS];
    assign BANK_FOUR_OE_N           = oe_n_q[3*BANK_OUTS +: BANK_OUTS];

    // ---------------- assertions ----------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_enable_fall;
        ctrl_prev.oe_n && !ctrl.oe_n;
    endsequence

    sequence s_held_unlocked;
        !lock_done [*8];
    endsequence

    oe_drive_a: assert property (!ctrl.oe_n |=> (oe_n_q == '0))
        else $error("outputs not driven while enabled");

    oe_float_a: assert property (ctrl.oe_n |=> (oe_n_q == '1) && (outs == '0))
        else $error("outputs driven while disabled");

    relock_oe_a: assert property (s_enable_fall |=> s_held_unlocked)
        else $error("lock reported too soon after enable");

    loop_path_a: assert property (loop_active ##1 1'b1 |->
        BANK_FOUR_CLOCK_OUTPUTS == {BANK_OUTS{$past(div[0])}})
        else $error("loop path not on outputs");

    bypass_out_a: assert property ((ctrl.test_mode && !ctrl.oe_n) |=>
        BANK_ONE_CLOCK_OUTPUTS == {BANK_OUTS{$past(ref_sync[1])}})
        else $error("bypass not on outputs");

    bank_ratio_a: assert property ((loop_active && ctrl.sel_high && ctrl.sel_low) |=>
        BANK_THREE_CLOCK_OUTPUTS == {BANK_OUTS{$past(div[1])}})
        else $error("bank three not slow for code three");

    bank_two_fast_a: assert property ((loop_active && !ctrl.sel_high && ctrl.sel_low) |=>
        BANK_TWO_CLOCK_OUTPUTS == {BANK_OUTS{$past(div[0])}})
        else $error("bank two not fast for code one");

    bank_four_a: assert property ((loop_active && ctrl.sel_high) |=>
        BANK_FOUR_CLOCK_OUTPUTS == {BANK_OUTS{$past(div[0])}})
        else $error("bank four not at half rate");

    div_step_a: assert property (!RST && !slip |=> div == $past(div) + 2'h1)
        else $error("divider did not advance");

    phase_slip_a: assert property (slip |=> div == $past(div))
        else $error("divider did not hold on slip");

    sel_relock_a: assert property ($changed(ctrl.sel_low) |-> ##1 s_held_unlocked)
        else $error("lock too soon after select change");

endmodule

// file: rtl/pcf_lock_timer.sv
// stabilization timer: holds not-locked for a fixed count after each restart
`timescale 1ns/1ps
module pcf_lock_timer
    import pcf_pkg::*;
#(
    parameter int unsigned CYCLES = STAB_MIN_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic restart,
    output logic      done
);

    logic [STAB_CNT_W-1:0] count;
    logic [STAB_CNT_W-1:0] next_count;
    logic                  next_done;

    localparam logic [STAB_CNT_W-1:0] LAST = STAB_CNT_W'(CYCLES - 1);

    always_comb begin
        next_count = count;
        next_done  = done;
        if (restart) begin
            next_count = '0;
            next_done  = 1'b0;
        end else if (!done) begin
            if (count == LAST) begin
                next_done = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= '0;
            done  <= 1'b0;
        end else begin
            count <= next_count;
            done  <= next_done;
        end
    end

endmodule

// file: rtl/pcf_pkg.sv
// shared constants and types of the clock fanout control block
package pcf_pkg;

    // register map (byte addresses on a 32-bit Avalon-MM slave)
    localparam int unsigned ADDR_W         = 4;
    localparam logic [3:0]  CTRL_ADDR      = 4'h0;
    localparam logic [3:0]  STATUS_ADDR    = 4'h4;

    // control register fields
    localparam int unsigned CTRL_SEL_LOW   = 0;
    localparam int unsigned CTRL_SEL_HIGH  = 1;
    localparam int unsigned CTRL_OE_N      = 2;
    localparam int unsigned CTRL_TEST      = 3;
    localparam int unsigned CTRL_CLEAR     = 4;
    localparam logic [4:0]  CTRL_RESET     = 5'h04;

    // status register fields
    localparam int unsigned STAT_LOCKED    = 0;
    localparam int unsigned STAT_PHASE_OK  = 1;
    localparam int unsigned STAT_TEST      = 2;
    localparam int unsigned STAT_OUT_OFF   = 3;

    // banks and outputs
    localparam int unsigned NUM_BANKS      = 4;
    localparam int unsigned BANK_OUTS      = 3;

    // stabilization interval after a restart event
    localparam int unsigned CORE_CLK_MHZ   = 100;
    localparam int unsigned STAB_TIME_US   = 50;
    localparam int unsigned STAB_MAX_CYC   = STAB_TIME_US * CORE_CLK_MHZ;
    localparam int unsigned STAB_MIN_CYC   = STAB_TIME_US * CORE_CLK_MHZ;
    localparam int unsigned STAB_CNT_W     = 16;

    // divider states of the oscillator model; bit 0 is osc/2, bit 1 is osc/4
    localparam logic [1:0]  DIV_RESET      = 2'h0;

    typedef struct packed {
        logic clear;
        logic test_mode;
        logic oe_n;
        logic sel_high;
        logic sel_low;
    } pcf_ctrl_t;

    typedef enum logic [2:0] {
        PCF_BUS_IDLE = 3'b001,
        PCF_BUS_ACK  = 3'b010,
        PCF_BUS_DONE = 3'b100
    } pcf_bus_state_t;

endpackage

// file: test/pcf_load_model.sv
// far-side load model: reference source and the wired-back feedback output
`timescale 1ns/1ps
module pcf_load_model (
    input  wire logic clk,
    input  wire logic ref_run,
    input  wire logic ref_level,
    input  wire logic fb_src,
    input  wire logic fb_oe_n,
    output logic      ref_clk = 1'b0,
    output logic      fb
);
    logic [1:0] phase     = 2'h0;
    logic       float_pat = 1'b0;
    // fixed frequency and phase: period of four core cycles
    always @(posedge clk) begin
        phase     <= phase + 2'h1;
        float_pat <= ~float_pat;
        ref_clk   <= ref_run ? phase[1] : ref_level;
    end
    // undriven feedback line keeps changing so a stale level cannot pass
    assign fb = fb_oe_n ? float_pat : fb_src;
endmodule

// file: test/pll_clock_fanout_control_tb.sv
// self-checking bench of the clock fanout control block
`timescale 1ns/1ps
module pll_clock_fanout_control_tb;
    import pcf_pkg::*;
    localparam int unsigned STAB = 20;
    logic              CORE_CLK    = 1'b0;
    logic              RST         = 1'b1;
    logic [ADDR_W-1:0] ADDRESS     = 4'h0;
    logic              READ        = 1'b0;
    logic              WRITE       = 1'b0;
    logic [31:0]       WRITEDATA   = 32'h0;
    logic [31:0]       READDATA;
    logic              WAITREQUEST;
    logic              ref_clk;
    logic              fb;
    logic              ref_run     = 1'b0;
    logic              ref_level   = 1'b0;
    logic [2:0]        b1, b2, b3, b4, o1, o2, o3, o4;
    int                miscompares = 0;
    int                tests_run   = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    pcf_clock_fanout #(.STAB_CYCLES(STAB)) i_pcf_clock_fanout (
        .CORE_CLK(CORE_CLK), .RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .REFERENCE_CLOCK_INPUT(ref_clk), .LOOP_FEEDBACK_INPUT(fb),
        .BANK_ONE_CLOCK_OUTPUTS(b1), .BANK_TWO_CLOCK_OUTPUTS(b2),
        .BANK_THREE_CLOCK_OUTPUTS(b3), .BANK_FOUR_CLOCK_OUTPUTS(b4),
        .BANK_ONE_OE_N(o1), .BANK_TWO_OE_N(o2), .BANK_THREE_OE_N(o3), .BANK_FOUR_OE_N(o4));

    pcf_load_model i_pcf_load_model (.clk(CORE_CLK), .ref_run(ref_run), .ref_level(ref_level),
        .fb_src(b4[0]), .fb_oe_n(o4[0]), .ref_clk(ref_clk), .fb(fb));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge CORE_CLK);
        READ      <= ~w;
        WRITE     <= w;
        ADDRESS   <= a;
        WRITEDATA <= d;
        n = 0;
        do begin
            @(posedge CORE_CLK);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 40);
        q = READDATA;
        READ  <= 1'b0;
        WRITE <= 1'b0;
        if (WAITREQUEST !== 1'b0) begin
            $display("Error waitrequest expected 0 seen %b", WAITREQUEST);
            miscompares++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    function automatic logic [31:0] ctl(logic [1:0] code, logic oe_n, logic test, logic clr);
        return {27'h0, clr, test, oe_n, code};
    endfunction

    // locked must stay low well inside the interval and be up after it
    task automatic relock();
        logic [31:0] q;
        rd(STATUS_ADDR, q);
        chk("locked after restart", 32'h0, q & 32'h1);
        repeat (8) @(posedge CORE_CLK);
        rd(STATUS_ADDR, q);
        chk("locked inside interval", 32'h0, q & 32'h1);
        repeat (STAB + 10) @(posedge CORE_CLK);
        rd(STATUS_ADDR, q);
        chk("locked after interval", 32'h1, q & 32'h1);
    endtask

    // ref stopped so no slip disturbs the divider during counting
    task automatic ratios(input logic [1:0] code);
        logic [11:0] prev, cur;
        int          tog [4];
        int          hi [4];
        int          bad;
        bad = 0;
        for (int b = 0; b < 4; b++) begin
            tog[b] = 0;
            hi[b]  = 0;
        end
        repeat (4) @(posedge CORE_CLK);
        prev = {b4, b3, b2, b1};
        for (int i = 0; i < 16; i++) begin
            @(posedge CORE_CLK);
            cur = {b4, b3, b2, b1};
            for (int b = 0; b < 4; b++) begin
                tog[b] += int'(cur[3*b] != prev[3*b]);
                hi[b]  += int'(cur[3*b]);
                bad    += int'(cur[3*b+:3] !== {3{cur[3*b]}});
            end
            prev = cur;
        end
        for (int b = 0; b < 4; b++) begin
            chk("bank toggles", (b < 3 && code > b) ? 32'd8 : 32'd16, tog[b]);
            chk("bank duty", 32'd8, hi[b]);
        end
        chk("bank fanout", 32'h0, bad);
    endtask

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        $display("Error timeout");
        miscompares++;
        stop_test();
    end

    initial begin
        logic [31:0] q;
        logic        clr;
        logic        lv;
        void'($urandom(32'h0bf3));
        repeat (6) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        chk("waitrequest idle", 32'h1, WAITREQUEST);
        chk("oe reset", 32'hfff, {o4, o3, o2, o1});
        chk("outputs reset", 32'h0, {b4, b3, b2, b1});
        rd(CTRL_ADDR, q);
        chk("ctrl reset", {27'h0, CTRL_RESET}, q);
        wr(4'h8, 32'h0);
        rd(4'h8, q);
        chk("unmapped read", 32'h0, q);
        rd(CTRL_ADDR, q);
        chk("ctrl after unmapped write", {27'h0, CTRL_RESET}, q);
        wr(CTRL_ADDR, ctl(2'h0, 1'b0, 1'b0, 1'b0));
        relock();
        $display("test reset and first lock done");
        for (int c = 0; c < 4; c++) begin
            clr = 1'($urandom);
            wr(CTRL_ADDR, ctl(2'(c), 1'b0, 1'b0, clr));
            rd(CTRL_ADDR, q);
            chk("ctrl readback", ctl(2'(c), 1'b0, 1'b0, clr), q);
            chk("oe enabled", 32'h0, {o4, o3, o2, o1});
            repeat ($urandom % 3) @(posedge CORE_CLK);
            ratios(2'(c));
        end
        $display("test bank ratios done");
        ref_run <= 1'b1;
        wr(CTRL_ADDR, ctl(2'h1, 1'b0, 1'b0, 1'b0));
        relock();
        wr(CTRL_ADDR, ctl(2'h1, 1'b1, 1'b0, 1'b0));
        repeat (3) @(posedge CORE_CLK);
        chk("oe disabled", 32'hfff, {o4, o3, o2, o1});
        chk("outputs disabled", 32'h0, {b4, b3, b2, b1});
        rd(STATUS_ADDR, q);
        chk("status off", 32'h8, q & 32'hd);
        wr(CTRL_ADDR, ctl(2'h1, 1'b0, 1'b0, 1'b0));
        relock();
        rd(STATUS_ADDR, q);
        chk("phase aligned", 32'h3, q & 32'h3);
        $display("test enable restart done");
        wr(CTRL_ADDR, ctl(2'h1, 1'b0, 1'b1, 1'b0));
        rd(STATUS_ADDR, q);
        chk("status test", 32'h4, q & 32'hd);
        ref_run <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            lv = 1'($urandom);
            ref_level <= lv;
            repeat (6) @(posedge CORE_CLK);
            chk("bypass outputs", {20'h0, {12{lv}}}, {b4, b3, b2, b1});
        end
        ref_run <= 1'b1;
        wr(CTRL_ADDR, ctl(2'h1, 1'b0, 1'b0, 1'b0));
        relock();
        $display("test bypass done");
        stop_test();
    end
endmodule
